/* core/supply_monitor_pkg.sv */
// Purpose: shared constants and types for the supply monitor flag logic
// Assumes: 10 MHz core clock, 8-bit special function register port
// Notes:   control register layout, reset value and timeout figures
package supply_monitor_pkg;

   // special function register port
   localparam logic [7:0] CTRL_ADDR     = 8'hDF;
   localparam logic [7:0] CTRL_RESET    = 8'hDE;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // control register field positions
   localparam int BIT_RSVD_HI      = 7;
   localparam int BIT_DIG_COMPARE  = 6;
   localparam int BIT_FAIL_FLAG    = 5;
   localparam int BIT_TRIP_HI      = 4;
   localparam int BIT_TRIP_LO      = 3;
   localparam int BIT_RSVD_MID     = 2;
   localparam int BIT_RSVD_LO      = 1;
   localparam int BIT_MON_ENABLE   = 0;

   // reserved bits read back as their power-on value
   localparam logic RSVD_READ      = 1'b1;

   // reset values of the writable fields
   localparam logic [1:0] TRIP_RESET   = 2'h3;
   localparam logic       ENABLE_RESET = 1'b0;
   localparam logic       FLAG_RESET   = 1'b0;

   // digital trip select codes
   typedef enum logic [1:0] {
      TRIP_RSVD_00 = 2'b00,
      TRIP_3V08    = 2'b01,
      TRIP_2V93    = 2'b10,
      TRIP_RSVD_11 = 2'b11
   } trip_code_t;

   // timing
   localparam int CLK_KHZ        = 10_000;
   localparam int TIMEOUT_MS     = 250;
   localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
   localparam int FILTER_CYCLES  = 4;

   // one register port request per cycle
   typedef struct packed {
      logic [7:0] addr;
      logic       wr_en;
      logic       rd_en;
      logic [7:0] wdata;
   } sfr_req_t;

endpackage

/* core/dip_filter.sv */
// Purpose: suppress short low-going dips on one comparator output
// Assumes: input already synchronous to clk
// Notes:   falls only after DEPTH consecutive low samples, rises at once
`timescale 1ns/1ps
module dip_filter #(
   parameter int DEPTH = supply_monitor_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // comparator
   input  wire logic raw_in,
   output logic      clean_ff
);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

   logic [CW-1:0] low_cnt_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_ff <= '0;
      end else if (raw_in || !clean_ff) begin
         low_cnt_ff <= '0;
      end else if (low_cnt_ff != LAST) begin
         low_cnt_ff <= low_cnt_ff + CW'(1);
      end
   end

   // supplies are assumed good coming out of reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         clean_ff <= 1'b1;
      end else if (raw_in) begin
         clean_ff <= 1'b1;
      end else if (low_cnt_ff == LAST) begin
         clean_ff <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_short_dip_held: assert property ($fell(raw_in) && clean_ff |=> clean_ff)
      else $error("single low sample reached the filtered output");
   // next-cycle check so that any depth up to eight has fallen by then
   a_long_low_seen: assert property (!raw_in [*8] |=> !clean_ff)
      else $error("sustained low not passed through the filter");

endmodule // dip_filter

/* core/supply_monitor_flag_logic.sv */
// Purpose: digital side of the supply monitor: flag, timeout, control register
// Assumes: 10 MHz clk, register port synchronous, comparator inputs synchronous
// Notes:   read data is registered and appears one cycle after the read request
`timescale 1ns/1ps
module supply_monitor_flag_logic #(
   parameter int TIMEOUT_CYCLES = supply_monitor_pkg::TIMEOUT_CYCLES,
   parameter int FILTER_CYCLES  = supply_monitor_pkg::FILTER_CYCLES
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   // special function register port
   input  wire supply_monitor_pkg::sfr_req_t sfr_req,
   output logic [7:0]                        sfr_rdata_ff,
   // analog comparators
   input  wire logic                         analog_supply_compare,
   input  wire logic                         digital_supply_compare,
   // analog trim and enable
   output logic [1:0]                        digital_trip_select_ff,
   output logic                              trip_level_valid_ff,
   output logic                              monitor_enable_ff,
   // interrupt to the core
   input  wire logic                         secondary_interrupt_enable,
   output logic                              supply_fail_irq_ff
);
   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [CW-1:0] CNT_LAST = CW'(TIMEOUT_CYCLES - 1);

   logic          analog_ok;
   logic          digital_ok;
   logic          supply_low;
   logic          ctrl_wr;
   logic          ctrl_rd;
   logic          supply_fail_flag_ff;
   logic          nxt_supply_fail_flag;
   logic [CW-1:0] good_cnt_ff;
   logic          expire;
   logic [7:0]    ctrl_view;

   // comparator dip filters
   dip_filter #(
      .DEPTH    (FILTER_CYCLES)
   ) u_analog_filter (
      .clk      (clk),
      .reset_n  (reset_n),
      .raw_in   (analog_supply_compare),
      .clean_ff (analog_ok)
   );

   dip_filter #(
      .DEPTH    (FILTER_CYCLES)
   ) u_digital_filter (
      .clk      (clk),
      .reset_n  (reset_n),
      .raw_in   (digital_supply_compare),
      .clean_ff (digital_ok)
   );

   assign ctrl_wr = sfr_req.wr_en && (sfr_req.addr == supply_monitor_pkg::CTRL_ADDR);
   assign ctrl_rd = sfr_req.rd_en && (sfr_req.addr == supply_monitor_pkg::CTRL_ADDR);

   // low supply only counts while monitoring is on
   assign supply_low = monitor_enable_ff && (!analog_ok || !digital_ok);

   // monitor enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         monitor_enable_ff <= supply_monitor_pkg::ENABLE_RESET;
      end else if (ctrl_wr) begin
         monitor_enable_ff <= sfr_req.wdata[supply_monitor_pkg::BIT_MON_ENABLE];
      end
   end

   // trip select field
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         digital_trip_select_ff <= supply_monitor_pkg::TRIP_RESET;
      end else if (ctrl_wr) begin
         digital_trip_select_ff <= {sfr_req.wdata[supply_monitor_pkg::BIT_TRIP_HI],
                                    sfr_req.wdata[supply_monitor_pkg::BIT_TRIP_LO]};
      end
   end

   // only the two defined codes give the analog side a usable level
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         trip_level_valid_ff <= 1'b0;
      end else begin
         case (supply_monitor_pkg::trip_code_t'(digital_trip_select_ff))
            supply_monitor_pkg::TRIP_3V08: trip_level_valid_ff <= 1'b1;
            supply_monitor_pkg::TRIP_2V93: trip_level_valid_ff <= 1'b1;
            supply_monitor_pkg::TRIP_RSVD_00,
            supply_monitor_pkg::TRIP_RSVD_11: trip_level_valid_ff <= 1'b0;
            default: trip_level_valid_ff <= 1'b0;
         endcase
      end
   end

   // good-supply timeout; held at zero while low or while the flag is clear
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         good_cnt_ff <= '0;
      end else if (supply_low || !supply_fail_flag_ff || expire) begin
         good_cnt_ff <= '0;
      end else begin
         good_cnt_ff <= good_cnt_ff + CW'(1);
      end
   end

   assign expire = supply_fail_flag_ff && !supply_low && (good_cnt_ff == CNT_LAST);

   // hardware set wins over any software clear and over expiry
   always_comb begin
      nxt_supply_fail_flag = supply_fail_flag_ff;
      if (supply_low) begin
         nxt_supply_fail_flag = 1'b1;
      end else if (ctrl_wr) begin
         nxt_supply_fail_flag = sfr_req.wdata[supply_monitor_pkg::BIT_FAIL_FLAG];
      end else if (expire) begin
         nxt_supply_fail_flag = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_fail_flag_ff <= supply_monitor_pkg::FLAG_RESET;
      end else begin
         supply_fail_flag_ff <= nxt_supply_fail_flag;
      end
   end

   // interrupt request
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         supply_fail_irq_ff <= 1'b0;
      end else begin
         supply_fail_irq_ff <= supply_fail_flag_ff && secondary_interrupt_enable;
      end
   end

   // register image; the comparator bit is the live unfiltered input
   always_comb begin
      ctrl_view = '0;
      ctrl_view[supply_monitor_pkg::BIT_RSVD_HI]     = supply_monitor_pkg::RSVD_READ;
      ctrl_view[supply_monitor_pkg::BIT_DIG_COMPARE] = digital_supply_compare;
      ctrl_view[supply_monitor_pkg::BIT_FAIL_FLAG]   = supply_fail_flag_ff;
      ctrl_view[supply_monitor_pkg::BIT_TRIP_HI]     = digital_trip_select_ff[1];
      ctrl_view[supply_monitor_pkg::BIT_TRIP_LO]     = digital_trip_select_ff[0];
      ctrl_view[supply_monitor_pkg::BIT_RSVD_MID]    = supply_monitor_pkg::RSVD_READ;
      ctrl_view[supply_monitor_pkg::BIT_RSVD_LO]     = supply_monitor_pkg::RSVD_READ;
      ctrl_view[supply_monitor_pkg::BIT_MON_ENABLE]  = monitor_enable_ff;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata_ff <= supply_monitor_pkg::READ_UNMAPPED;
      end else if (ctrl_rd) begin
         sfr_rdata_ff <= ctrl_view;
      end else begin
         sfr_rdata_ff <= supply_monitor_pkg::READ_UNMAPPED;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_good_timed_out;
      supply_fail_flag_ff && !supply_low && (good_cnt_ff == CNT_LAST) && !ctrl_wr;
   endsequence

   sequence s_clear_attempt;
      ctrl_wr && !sfr_req.wdata[supply_monitor_pkg::BIT_FAIL_FLAG];
   endsequence

   a_flag_sets_low: assert property (supply_low |=> supply_fail_flag_ff)
      else $error("low supply did not set the failure flag");

   a_clear_blocked: assert property (s_clear_attempt and supply_low
                                     |=> supply_fail_flag_ff)
      else $error("software cleared the flag while a supply was low");

   a_timeout_clears: assert property (s_good_timed_out |=> !supply_fail_flag_ff)
      else $error("flag not cleared on timeout expiry");

   a_count_restart: assert property (supply_low |=> good_cnt_ff == '0)
      else $error("timeout count not restarted by a low supply");

   a_count_advance: assert property (supply_fail_flag_ff && !supply_low && !expire
                                     && !ctrl_wr
                                     |=> good_cnt_ff == $past(good_cnt_ff) + CW'(1))
      else $error("timeout count stalled while supplies good");

   a_sw_write_flag: assert property (ctrl_wr && !supply_low
                                     |=> supply_fail_flag_ff
                                         == $past(sfr_req.wdata[supply_monitor_pkg::BIT_FAIL_FLAG]))
      else $error("software write to the flag not applied");

   a_irq_follows: assert property (supply_fail_flag_ff && secondary_interrupt_enable
                                   |=> supply_fail_irq_ff)
      else $error("interrupt not raised for an enabled failure flag");

   a_irq_masked: assert property (!secondary_interrupt_enable |=> !supply_fail_irq_ff)
      else $error("interrupt raised while disabled");

   a_compare_live: assert property (ctrl_rd |=> sfr_rdata_ff[supply_monitor_pkg::BIT_DIG_COMPARE]
                                    == $past(digital_supply_compare))
      else $error("comparator status bit not live");

   a_enable_write: assert property (ctrl_wr |=> monitor_enable_ff
                                    == $past(sfr_req.wdata[supply_monitor_pkg::BIT_MON_ENABLE]))
      else $error("monitor enable not taken from the write");

   a_disabled_no_set: assert property (!monitor_enable_ff && !supply_fail_flag_ff && !ctrl_wr
                                       |=> !supply_fail_flag_ff)
      else $error("flag set while monitoring was off");

   a_trip_valid: assert property (ctrl_wr ##1 1'b1
                                  |=> trip_level_valid_ff
                                      == ($past(digital_trip_select_ff) == 2'b01
                                          || $past(digital_trip_select_ff) == 2'b10))
      else $error("trip level valid disagrees with select code");

endmodule // supply_monitor_flag_logic

/* test/test_supply_monitor_flag_logic.sv */
// Purpose: self-checking bench for the supply monitor flag logic
// Assumes: short timeout (20 cycles) and filter depth 4 for simulation
// Notes:   tasks start and end 1 ns after a rising clock edge
`timescale 1ns/1ps
module test_supply_monitor_flag_logic;
   localparam int TMO = 20;
   localparam logic [7:0] A = supply_monitor_pkg::CTRL_ADDR;

   typedef struct packed {
      logic [7:0] wdata;
      logic [1:0] trip;
      logic       valid;
      logic       en;
      logic [7:0] image;
   } row_t;

   logic                         clk;
   logic                         reset_n;
   supply_monitor_pkg::sfr_req_t sfr_req;
   logic [7:0]                   sfr_rdata_ff;
   logic                         cmp_a;
   logic                         cmp_d;
   logic [1:0]                   trip_ff;
   logic                         valid_ff;
   logic                         en_ff;
   logic                         irq_en;
   logic                         irq_ff;
   logic [7:0]                   d;
   int                           n_fail;
   int                           total_checks;
   row_t                         rows [4];

   supply_monitor_flag_logic #(.TIMEOUT_CYCLES(TMO), .FILTER_CYCLES(4)) dut (
      .clk                        (clk),
      .reset_n                    (reset_n),
      .sfr_req                    (sfr_req),
      .sfr_rdata_ff               (sfr_rdata_ff),
      .analog_supply_compare      (cmp_a),
      .digital_supply_compare     (cmp_d),
      .digital_trip_select_ff     (trip_ff),
      .trip_level_valid_ff        (valid_ff),
      .monitor_enable_ff          (en_ff),
      .secondary_interrupt_enable (irq_en),
      .supply_fail_irq_ff         (irq_ff)
   );

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      sfr_req.addr  = a;
      sfr_req.wdata = v;
      sfr_req.wr_en = 1'b1;
      cyc(1);
      sfr_req.wr_en = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      sfr_req.addr  = a;
      sfr_req.rd_en = 1'b1;
      cyc(1);
      v = sfr_rdata_ff;
      sfr_req.rd_en = 1'b0;
   endtask

   initial begin
      #400_000;
      n_fail++;
      tally_and_finish();
   end

   initial begin
      reset_n = 1'b0;
      sfr_req = '0;
      cmp_a   = 1'b1;
      cmp_d   = 1'b1;
      irq_en  = 1'b1;
      n_fail  = 0;
      total_checks = 0;
      rows[0] = '{8'hC7, 2'b00, 1'b0, 1'b1, 8'hC7};
      rows[1] = '{8'h09, 2'b01, 1'b1, 1'b1, 8'hCF};
      rows[2] = '{8'h11, 2'b10, 1'b1, 1'b1, 8'hD7};
      rows[3] = '{8'h18, 2'b11, 1'b0, 1'b0, 8'hDE};
      cyc(3);
      reset_n = 1'b1;
      check({6'h00, trip_ff}, 8'h03);
      check({7'h00, en_ff}, 8'h00);
      check({7'h00, irq_ff}, 8'h00);
      rd(A, d);
      check(d, supply_monitor_pkg::CTRL_RESET);
      // trip codes and enable through the register
      foreach (rows[i]) begin
         wr(A, rows[i].wdata);
         cyc(1);
         check({6'h00, trip_ff}, {6'h00, rows[i].trip});
         check({7'h00, valid_ff}, {7'h00, rows[i].valid});
         check({7'h00, en_ff}, {7'h00, rows[i].en});
         rd(A, d);
         check(d, rows[i].image);
      end
      // unmapped address
      wr(8'h5A, 8'h09);
      rd(8'h5A, d);
      check(d, supply_monitor_pkg::READ_UNMAPPED);
      rd(A, d);
      check(d, 8'hDE);
      // monitor off: long dip must not set the flag
      wr(A, 8'h08);
      cmp_d = 1'b0;
      cyc(8);
      rd(A, d);
      check(d, 8'h8E);
      cmp_d = 1'b1;
      cyc(2);
      // monitor on: short glitch is filtered
      wr(A, 8'h09);
      cmp_d = 1'b0;
      cyc(3);
      cmp_d = 1'b1;
      cyc(4);
      rd(A, d);
      check(d, 8'hCF);
      check({7'h00, irq_ff}, 8'h00);
      // real dip sets flag and interrupt
      cmp_d = 1'b0;
      cyc(7);
      rd(A, d);
      check(d, 8'hAF);
      check({7'h00, irq_ff}, 8'h01);
      wr(A, 8'h09);
      rd(A, d);
      check(d, 8'hAF);
      irq_en = 1'b0;
      cyc(2);
      check({7'h00, irq_ff}, 8'h00);
      irq_en = 1'b1;
      // recovery, then analog dip restarts the count
      cmp_d = 1'b1;
      cyc(10);
      rd(A, d);
      check(d, 8'hEF);
      cmp_a = 1'b0;
      cyc(6);
      cmp_a = 1'b1;
      cyc(15);
      rd(A, d);
      check(d, 8'hEF);
      cyc(10);
      rd(A, d);
      check(d, 8'hCF);
      cyc(1);
      check({7'h00, irq_ff}, 8'h00);
      // software set with good supplies, interrupt masked
      irq_en = 1'b0;
      wr(A, 8'h29);
      rd(A, d);
      check(d, 8'hEF);
      check({7'h00, irq_ff}, 8'h00);
      cyc(TMO + 5);
      rd(A, d);
      check(d, 8'hCF);
      tally_and_finish();
   end
endmodule // test_supply_monitor_flag_logic
